// *** src/clock_fault_monitor.sv ***
// Clock fault supervision: signal loss, frequency range, lock loss, status and output control.
`timescale 1ns/1ps
// Notes on behaviour
// - Loops switch inputs up to 500 ppm apart
// - Lock loss asserted while loop pulls in
// - Glitchless switch produces no output runt pulse
// - Valid gapped clock raises no fault monitor
// - Inputs 0-2, reference: loss and range; crystal: loss
// - Loss detector times periods, programmable sensitivity
// - Signal loss has live and sticky bits
// - Inputs 3/4 drive holdover only when single
// - Crystal loss disables outputs unless configured otherwise
// - Range status combines precision and fast monitors
// - Precision window in 1/16 ppm, hysteresis
// - Frequency reference selectable among sources
// - Fast monitor flags beyond 4000 ppm
// - Lock loss live, sticky, active-low pins
// - Separate set and clear thresholds
// - Optional timer delays lock-loss clearing
// - Maskable interrupt pin on status change
// - Clearing sticky bits releases interrupt pin
// - Crosspoint feeds any output from any loop
// - Output 6 cascades dividers for 1 Hz
module clock_fault_monitor (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [6:0] clk_pins_in, // in0, in1, in2, ref, xtal, in3, in4
	input wire logic [4:0][19:0] freq_offset_in, // Signed, 1/16 ppm, vs local timebase
	input wire logic freq_valid_in, // Pulse: new precision measurement
	input wire logic [3:0][17:0] pd_diff_in, // Signed phase detector difference, 0.1 ppm
	output logic [31:0] rdata_out,
	output logic irq_pin_n_out,
	output logic loop_a_lock_loss_n_out,
	output logic loop_c_lock_loss_n_out,
	output logic loop_d_lock_loss_n_out,
	output logic ref_lock_loss_n_out,
	output logic crystal_loss_alarm_out,
	output logic holdover_d_out,
	output logic [6:0] out_enable_out,
	output logic [13:0] out_pll_sel_out,
	output logic [8:0] loop_sel_out,
	output logic cascade_1hz_out
);
	// Complete state of the block
	typedef struct packed {
		logic [6:0] sync1; // First synchroniser stage, read only by sync2
		logic [6:0] sync2;
		logic [6:0] sync3;
		logic [6:0] flt; // Agreed pin level
		logic [6:0][15:0] per_cnt; // Cycles since last rising edge or period timeout
		logic [6:0][3:0] miss_cnt; // Consecutive missing periods
		logic [6:0] signal_loss; // Signal loss per channel
		logic [3:0] prec_oof; // Precision monitor result
		logic [3:0] freq_out_of_range; // Combined range status
		logic [3:0] lock_loss;
		logic [3:0][15:0] lol_tmr; // Clear-delay timers
		logic [6:0] tick_cnt; // Microsecond divider
		logic [12:0] live_prev;
		logic [12:0] sticky;
		logic [12:0] mask;
		logic [10:0] ctrl;
		logic [12:0] oof_win;
		logic [12:0] oof_hyst;
		logic [27:0] los_sens;
		logic [16:0] lol_set;
		logic [16:0] lol_clr;
		logic [15:0] lol_dly;
		logic [8:0] loop_sel;
		logic [13:0] xpoint;
		logic [15:0] los_per;
		logic [31:0] rdata;
		logic irq_n;
		logic [3:0] lol_pin_n;
		logic xtal_alarm;
		logic holdover_d;
		logic [6:0] out_en;
	} state_t;

	state_t st_q, st_d;

	// Crystal reference code, declared ahead of the function that decodes it
	localparam logic [2:0] REFSEL_XTAL_C = clock_fault_monitor_pkg::REFSEL_XTAL;

	// Magnitude of a signed frequency offset
	function automatic logic [19:0] mag20(input logic [19:0] v);
		mag20 = v[19] ? 20'(-v) : v;
	endfunction : mag20

	// Magnitude of a signed phase detector difference
	function automatic logic [17:0] mag18(input logic [17:0] v);
		mag18 = v[17] ? 18'(-v) : v;
	endfunction : mag18

	// Offset of the selected 0 ppm reference
	function automatic logic [19:0] ref_offset(input logic [2:0] sel,
			input logic [4:0][19:0] offs);
		case (sel)
			3'h1: ref_offset = offs[0];
			3'h2: ref_offset = offs[1];
			3'h3: ref_offset = offs[2];
			REFSEL_XTAL_C: ref_offset = offs[4];
			default: ref_offset = offs[3];
		endcase
	endfunction : ref_offset

	// Combinational next state
	always_comb begin
		logic [12:0] live;
		logic [12:0] clr_bits;
		logic [19:0] refo;
		logic [19:0] d;
		logic [19:0] lo_bound;
		logic fast_hit;
		logic tick;
		logic [17:0] pd;
		logic [2:0] new_sel;
		live = '0;
		clr_bits = '0;
		refo = '0;
		d = '0;
		lo_bound = '0;
		fast_hit = 1'b0;
		tick = 1'b0;
		pd = '0;
		new_sel = '0;
		st_d = st_q;
		// Three-stage pin synchronisers; level accepted once stages two and three agree
		st_d.sync1 = clk_pins_in;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = st_q.sync2;
		for (int i = 0; i < clock_fault_monitor_pkg::N_MON; i++) begin
			if (st_q.sync2[i] == st_q.sync3[i]) begin
				st_d.flt[i] = st_q.sync3[i];
			end
			// Period timing per channel; sampling and the two-stage agreement limit useful inputs to at most 25 MHz
			if (st_d.flt[i] && !st_q.flt[i]) begin
				st_d.per_cnt[i] = '0;
				st_d.miss_cnt[i] = '0;
				st_d.signal_loss[i] = 1'b0;
			end else if (st_q.per_cnt[i] >= st_q.los_per) begin
				st_d.per_cnt[i] = '0;
				// One more missing period; isolated gaps stay below the sensitivity
				if (st_q.miss_cnt[i] != 4'hf) begin
					st_d.miss_cnt[i] = st_q.miss_cnt[i] + 4'h1;
				end
				if (st_q.miss_cnt[i] >= st_q.los_sens[i*4 +: 4]) begin
					st_d.signal_loss[i] = 1'b1;
				end
			end else begin
				st_d.per_cnt[i] = st_q.per_cnt[i] + 16'h0001;
			end
		end
		// Frequency range on inputs 0..2 and the stable reference
		refo = ref_offset(st_q.ctrl[clock_fault_monitor_pkg::CTRL_REF_LSB +: 3],
			freq_offset_in);
		lo_bound = (st_q.oof_hyst > st_q.oof_win) ? 20'h0 :
			20'(st_q.oof_win - st_q.oof_hyst);
		for (int i = 0; i < 4; i++) begin
			d = mag20(20'(freq_offset_in[i] - refo));
			// Fast monitor acts every cycle to catch a ramping input
			fast_hit = d > clock_fault_monitor_pkg::FAST_LIMIT;
			// Precision monitor updates only with a finished measurement
			if (freq_valid_in) begin
				if (d > 20'(st_q.oof_win)) begin
					st_d.prec_oof[i] = 1'b1;
				end else if (d < lo_bound) begin
					st_d.prec_oof[i] = 1'b0;
				end
			end
			st_d.freq_out_of_range[i] = (st_q.ctrl[clock_fault_monitor_pkg::CTRL_PREC_EN] & st_d.prec_oof[i])
				| (st_q.ctrl[clock_fault_monitor_pkg::CTRL_FAST_EN] & fast_hit);
		end
		// Microsecond enable for the clear-delay timers
		if (st_q.tick_cnt == clock_fault_monitor_pkg::TICK_LAST) begin
			st_d.tick_cnt = '0;
			tick = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 7'h01;
		end
		// Lock loss with set and clear comparators and clear-delay timer
		for (int i = 0; i < 4; i++) begin
			pd = mag18(pd_diff_in[i]);
			if (pd > 18'(st_q.lol_set)) begin
				st_d.lock_loss[i] = 1'b1;
				st_d.lol_tmr[i] = '0;
			end else if (st_q.lock_loss[i] && pd < 18'(st_q.lol_clr)) begin
				if (st_q.lol_tmr[i] >= st_q.lol_dly) begin
					st_d.lock_loss[i] = 1'b0;
				end else if (tick) begin
					st_d.lol_tmr[i] = st_q.lol_tmr[i] + 16'h0001;
				end
			end else begin
				st_d.lol_tmr[i] = '0; // Any excursion restarts the settle time
			end
		end
		// Register writes
		if (wr_in) begin
			case (addr_in)
				clock_fault_monitor_pkg::CTRL_OFS: st_d.ctrl = wdata_in[10:0];
				clock_fault_monitor_pkg::STICKY_OFS: clr_bits = wdata_in[12:0];
				clock_fault_monitor_pkg::MASK_OFS: st_d.mask = wdata_in[12:0];
				clock_fault_monitor_pkg::OOF_WIN_OFS: begin
					st_d.oof_win = wdata_in[12:0];
					st_d.oof_hyst = wdata_in[28:16];
				end
				clock_fault_monitor_pkg::LOS_SENS_OFS: st_d.los_sens = wdata_in[27:0];
				clock_fault_monitor_pkg::LOL_SET_OFS: st_d.lol_set = wdata_in[16:0];
				clock_fault_monitor_pkg::LOL_CLR_OFS: st_d.lol_clr = wdata_in[16:0];
				clock_fault_monitor_pkg::LOL_DLY_OFS: st_d.lol_dly = wdata_in[15:0];
				clock_fault_monitor_pkg::LOOP_SEL_OFS: begin
					st_d.loop_sel = wdata_in[8:0];
					// A new input means pull-in; hold lock loss until the clear path runs
					for (int l = 0; l < 3; l++) begin
						new_sel = wdata_in[l*3 +: 3];
						if (new_sel != st_q.loop_sel[l*3 +: 3]) begin
							st_d.lock_loss[l] = 1'b1;
							st_d.lol_tmr[l] = '0;
						end
					end
				end
				clock_fault_monitor_pkg::XPOINT_OFS: st_d.xpoint = wdata_in[13:0];
				clock_fault_monitor_pkg::LOS_PER_OFS: st_d.los_per = wdata_in[15:0];
				default: begin
					// Unmapped and read-only addresses ignore writes
				end
			endcase
		end
		// Live status; inputs 3 and 4 stay out of it
		live = {st_d.lock_loss, st_d.freq_out_of_range, st_d.signal_loss[4:0]};
		st_d.live_prev = live;
		// Changes set sticky bits; a change beats a clear in the same cycle
		st_d.sticky = (st_q.sticky & ~clr_bits) | (live ^ st_q.live_prev);
		// Interrupt pin low while any unmasked sticky bit stands
		st_d.irq_n = ~|(st_d.sticky & ~st_d.mask);
		st_d.lol_pin_n = ~st_d.lock_loss;
		st_d.xtal_alarm = st_d.signal_loss[4];
		// Inputs 3/4 feed holdover only when loop d uses just one of them
		if (st_d.ctrl[clock_fault_monitor_pkg::CTRL_IN34_BOTH]) begin
			st_d.holdover_d = 1'b0;
		end else begin
			st_d.holdover_d = st_d.ctrl[clock_fault_monitor_pkg::CTRL_IN34_SEL] ?
				st_d.signal_loss[6] : st_d.signal_loss[5];
		end
		// Outputs off on crystal loss unless told to keep running
		st_d.out_en = (st_d.signal_loss[4] && !st_d.ctrl[clock_fault_monitor_pkg::CTRL_KEEP_OUT]) ?
			7'h00 : 7'h7f;
		// Register reads, data in the following cycle
		st_d.rdata = '0;
		if (rd_in) begin
			case (addr_in)
				clock_fault_monitor_pkg::CTRL_OFS: st_d.rdata = {21'h0, st_q.ctrl};
				clock_fault_monitor_pkg::LIVE_OFS: st_d.rdata = {19'h0, st_q.live_prev};
				clock_fault_monitor_pkg::STICKY_OFS: st_d.rdata = {19'h0, st_q.sticky};
				clock_fault_monitor_pkg::MASK_OFS: st_d.rdata = {19'h0, st_q.mask};
				clock_fault_monitor_pkg::OOF_WIN_OFS:
					st_d.rdata = {3'h0, st_q.oof_hyst, 3'h0, st_q.oof_win};
				clock_fault_monitor_pkg::LOS_SENS_OFS: st_d.rdata = {4'h0, st_q.los_sens};
				clock_fault_monitor_pkg::LOL_SET_OFS: st_d.rdata = {15'h0, st_q.lol_set};
				clock_fault_monitor_pkg::LOL_CLR_OFS: st_d.rdata = {15'h0, st_q.lol_clr};
				clock_fault_monitor_pkg::LOL_DLY_OFS: st_d.rdata = {16'h0, st_q.lol_dly};
				clock_fault_monitor_pkg::LOOP_SEL_OFS: st_d.rdata = {23'h0, st_q.loop_sel};
				clock_fault_monitor_pkg::XPOINT_OFS: st_d.rdata = {18'h0, st_q.xpoint};
				clock_fault_monitor_pkg::LOS_PER_OFS: st_d.rdata = {16'h0, st_q.los_per};
				default: st_d.rdata = '0; // Unmapped reads return zero
			endcase
		end
	end

	// State register
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
			st_q.ctrl <= clock_fault_monitor_pkg::CTRL_RST;
			st_q.mask <= clock_fault_monitor_pkg::MASK_RST;
			st_q.oof_win <= clock_fault_monitor_pkg::OOF_WIN_RST;
			st_q.oof_hyst <= clock_fault_monitor_pkg::OOF_HYST_RST;
			st_q.los_sens <= clock_fault_monitor_pkg::LOS_SENS_RST;
			st_q.lol_set <= clock_fault_monitor_pkg::LOL_SET_RST;
			st_q.lol_clr <= clock_fault_monitor_pkg::LOL_CLR_RST;
			st_q.lol_dly <= clock_fault_monitor_pkg::LOL_DLY_RST;
			st_q.loop_sel <= clock_fault_monitor_pkg::LOOP_SEL_RST;
			st_q.xpoint <= clock_fault_monitor_pkg::XPOINT_RST;
			st_q.los_per <= clock_fault_monitor_pkg::LOS_PER_RST;
			st_q.irq_n <= 1'b1;
			st_q.lol_pin_n <= 4'hf;
			st_q.out_en <= 7'h7f;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign rdata_out = st_q.rdata;
	assign irq_pin_n_out = st_q.irq_n;
	assign loop_a_lock_loss_n_out = st_q.lol_pin_n[0];
	assign loop_c_lock_loss_n_out = st_q.lol_pin_n[1];
	assign loop_d_lock_loss_n_out = st_q.lol_pin_n[2];
	assign ref_lock_loss_n_out = st_q.lol_pin_n[3];
	assign crystal_loss_alarm_out = st_q.xtal_alarm;
	assign holdover_d_out = st_q.holdover_d;
	assign out_enable_out = st_q.out_en;
	assign out_pll_sel_out = st_q.xpoint;
	// Switching itself is left to the loops, which keep output edges whole
	assign loop_sel_out = st_q.loop_sel;
	// Output 5 must stay at or below 33.5 MHz while this is set
	assign cascade_1hz_out = st_q.ctrl[clock_fault_monitor_pkg::CTRL_CASCADE];

	// Changed status always lands in the sticky register
	a_sticky_change_set: assert property (@(posedge clock_in) disable iff (!rstn_in)
		((st_q.live_prev ^ $past(st_q.live_prev)) & ~st_q.sticky) == 13'h0)
		else $error("status change not captured in sticky bits");

	// Unmasked sticky bit pulls the interrupt pin low
	a_irq_pin_level: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(|(st_q.sticky & ~st_q.mask)) != irq_pin_n_out)
		else $error("interrupt pin disagrees with sticky and mask");

	// Clearing all sticky bits with no new change releases the pin
	a_irq_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(wr_in && addr_in == clock_fault_monitor_pkg::STICKY_OFS && wdata_in[12:0] == 13'h1fff
		&& st_d.live_prev == st_q.live_prev) |=> irq_pin_n_out)
		else $error("interrupt pin not released after sticky clear");

	// Crystal loss without keep-running blanks every output
	a_xtal_outputs_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(crystal_loss_alarm_out && !st_q.ctrl[clock_fault_monitor_pkg::CTRL_KEEP_OUT])
		|-> out_enable_out == 7'h00)
		else $error("outputs running during crystal loss");

	// New input on loop a forces lock loss next cycle
	a_pullin_lock_loss: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(wr_in && addr_in == clock_fault_monitor_pkg::LOOP_SEL_OFS
		&& wdata_in[2:0] != st_q.loop_sel[2:0]) |=> !loop_a_lock_loss_n_out)
		else $error("no lock loss during pull-in");

	// Difference beyond set threshold raises lock loss
	a_lol_set_level: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(mag18(pd_diff_in[1]) > 18'(st_q.lol_set)) |=> !loop_c_lock_loss_n_out)
		else $error("lock loss not set above threshold");

	// Lock loss holds while the difference is not under the clear threshold
	a_lol_clear_cond: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(!loop_a_lock_loss_n_out && mag18(pd_diff_in[0]) >= 18'(st_q.lol_clr))
		|=> !loop_a_lock_loss_n_out)
		else $error("lock loss cleared above clear threshold");

	// Agreed rising edge clears signal loss
	a_los_edge_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(st_q.flt[0]) |-> !st_q.signal_loss[0])
		else $error("signal loss stands after an edge");

	// Both inputs 3 and 4 in use keeps holdover request low
	a_holdover_both: assert property (@(posedge clock_in) disable iff (!rstn_in)
		st_q.ctrl[clock_fault_monitor_pkg::CTRL_IN34_BOTH] |-> !holdover_d_out)
		else $error("holdover driven with both inputs in use");

	// Fast monitor flags a large offset on input 0
	a_fast_oof: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(st_q.ctrl[clock_fault_monitor_pkg::CTRL_FAST_EN]
		&& mag20(20'(freq_offset_in[0] - ref_offset(st_q.ctrl[10:8], freq_offset_in)))
		> clock_fault_monitor_pkg::FAST_LIMIT) |=> st_q.freq_out_of_range[0])
		else $error("fast monitor missed large offset");

	// Read data stand only in the cycle after the strobe
	a_read_live: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(rd_in && addr_in == clock_fault_monitor_pkg::LIVE_OFS)
		|=> rdata_out == {19'h0, $past(st_q.live_prev)} ##1 ($past(rd_in) || rdata_out == 32'h0))
		else $error("live status read data wrong");
endmodule : clock_fault_monitor

// *** src/clock_fault_monitor_pkg.sv ***
// Constants shared by the clock fault monitor: register map, field layout, reset values.
package clock_fault_monitor_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00; // Monitor enables, reference select, output options
	localparam logic [7:0] LIVE_OFS = 8'h04; // Live status, read only
	localparam logic [7:0] STICKY_OFS = 8'h08; // Sticky status, write one to clear
	localparam logic [7:0] MASK_OFS = 8'h0c; // Interrupt mask, one blocks
	localparam logic [7:0] OOF_WIN_OFS = 8'h10; // Valid window and hysteresis, 1/16 ppm units
	localparam logic [7:0] LOS_SENS_OFS = 8'h14; // Tolerated missing periods, 4 bits per channel
	localparam logic [7:0] LOL_SET_OFS = 8'h18; // Lock-loss set threshold, 0.1 ppm units
	localparam logic [7:0] LOL_CLR_OFS = 8'h1c; // Lock-loss clear threshold, 0.1 ppm units
	localparam logic [7:0] LOL_DLY_OFS = 8'h20; // Lock-loss clear delay, microseconds
	localparam logic [7:0] LOOP_SEL_OFS = 8'h24; // Input selection of loops a, c, d
	localparam logic [7:0] XPOINT_OFS = 8'h28; // Output crosspoint, 2 bits per output
	localparam logic [7:0] LOS_PER_OFS = 8'h2c; // Longest accepted input period, clock cycles
	// Control field positions
	localparam int CTRL_FAST_EN = 0; // Fast frequency monitor enable
	localparam int CTRL_PREC_EN = 1; // Precision frequency monitor enable
	localparam int CTRL_KEEP_OUT = 2; // Keep outputs running on crystal loss
	localparam int CTRL_CASCADE = 3; // Output 6 cascades dividers 5 and 6 for 1 Hz
	localparam int CTRL_IN34_BOTH = 4; // Loop d uses both inputs 3 and 4
	localparam int CTRL_IN34_SEL = 5; // Single input used by loop d: 0 input 3, 1 input 4
	localparam int CTRL_REF_LSB = 8; // Reference select, 3 bits
	// Status layout: 0..4 signal loss, 5..8 frequency range, 9..12 lock loss
	localparam int LOS_LSB = 0;
	localparam int OOF_LSB = 5;
	localparam int LOL_LSB = 9;
	localparam int STAT_W = 13;
	// Reference select codes
	localparam logic [2:0] REFSEL_STABLE = 3'h0; // Stable reference input
	localparam logic [2:0] REFSEL_XTAL = 3'h4; // Crystal input; 1..3 pick inputs 0..2
	// Reset values
	localparam logic [10:0] CTRL_RST = 11'h003;
	localparam logic [12:0] MASK_RST = 13'h1fff;
	localparam logic [12:0] OOF_WIN_RST = 13'h1f40; // 500 ppm
	localparam logic [12:0] OOF_HYST_RST = 13'h0020; // 2 ppm
	localparam logic [27:0] LOS_SENS_RST = 28'h2222222; // Two misses ignored, fits gapped clocks
	localparam logic [16:0] LOL_SET_RST = 17'h0000a; // 1 ppm
	localparam logic [16:0] LOL_CLR_RST = 17'h00001; // 0.1 ppm
	localparam logic [15:0] LOL_DLY_RST = 16'h0000;
	localparam logic [8:0] LOOP_SEL_RST = 9'h000;
	localparam logic [13:0] XPOINT_RST = 14'h0000;
	localparam logic [15:0] LOS_PER_RST = 16'h0064;
	// Limits and timing
	localparam logic [19:0] FAST_LIMIT = 20'd64000; // 4000 ppm in 1/16 ppm units
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000; // Lock-loss delay timebase
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
	localparam int N_MON = 7; // in0, in1, in2, ref, xtal, in3, in4
	localparam int N_OUT = 7;
endpackage : clock_fault_monitor_pkg

// *** bench/clock_sources.sv ***
// Upstream clock sources: seven 10 MHz pin clocks, each stoppable or gapped.
`timescale 1ns/1ps
module clock_sources (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [6:0] run_in, // High lets a source toggle
	input wire logic [6:0] gap_in, // High drops two periods in eight
	output logic [6:0] clk_pins_out
);
	logic [2:0] ph_q; // Half-period phase, five cycles per half
	logic [2:0] per_q; // Period index within a group of eight
	logic half_q; // Common clock level before gating
	// Shared divider; all sources keep one phase, which is enough here
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ph_q <= 3'h0;
			per_q <= 3'h0;
			half_q <= 1'b0;
		end else if (ph_q == 3'h4) begin
			ph_q <= 3'h0;
			half_q <= ~half_q;
			if (half_q) begin // Falling edge ends a period
				per_q <= per_q + 3'h1;
			end
		end else begin
			ph_q <= ph_q + 3'h1;
		end
	end
	// A stopped source rests low; gapped ones skip periods 6 and 7
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			clk_pins_out[i] = run_in[i] & half_q & ~(gap_in[i] & per_q[2] & per_q[1]);
		end
	end
endmodule : clock_sources

// *** bench/tb.sv ***
// Self-checking bench for the clock fault monitor.
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CTRL = clock_fault_monitor_pkg::CTRL_OFS;
	localparam logic [7:0] LIVE = clock_fault_monitor_pkg::LIVE_OFS;
	localparam logic [7:0] STICKY = clock_fault_monitor_pkg::STICKY_OFS;
	logic clock_in, rstn_in, wr_in, rd_in, freq_valid_in;
	logic [7:0] addr_in;
	logic [31:0] wdata_in, rdata_out, v; // v holds the last read word
	logic [4:0][19:0] offs;
	logic [3:0][17:0] pd;
	logic [6:0] run, gap, pins, out_en;
	logic [13:0] xsel;
	logic [8:0] lsel;
	logic irq_n, la_n, lc_n, ld_n, lr_n, xalarm, hold, casc;
	int failures = 0;
	int samples_checked = 0;
	clock_sources src (.clock_in(clock_in), .rstn_in(rstn_in), .run_in(run), .gap_in(gap),
		.clk_pins_out(pins));
	clock_fault_monitor uut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .clk_pins_in(pins),
		.freq_offset_in(offs), .freq_valid_in(freq_valid_in), .pd_diff_in(pd),
		.rdata_out(rdata_out), .irq_pin_n_out(irq_n), .loop_a_lock_loss_n_out(la_n),
		.loop_c_lock_loss_n_out(lc_n), .loop_d_lock_loss_n_out(ld_n),
		.ref_lock_loss_n_out(lr_n), .crystal_loss_alarm_out(xalarm), .holdover_d_out(hold),
		.out_enable_out(out_en), .out_pll_sel_out(xsel), .loop_sel_out(lsel),
		.cascade_1hz_out(casc));
	// Free-running 100 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// Single comparison point; case inequality keeps unknowns from matching
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
		@(negedge clock_in); // Let the write's effects settle
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		v = rdata_out;
	endtask : rd
	// Bounded wait for a live bit to reach a level, then judge it
	task automatic poll(input int b, input logic val, input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(LIVE);
			if (v[b] === val) break;
		end
		check(32'(v[b]), 32'(val));
	endtask : poll
	task automatic meas;
		@(posedge clock_in);
		freq_valid_in <= 1'b1;
		@(posedge clock_in);
		freq_valid_in <= 1'b0;
	endtask : meas
	task automatic t_reset;
		rd(CTRL); check(v, 32'h003);
		rd(8'h0c); check(v, 32'h1fff);
		rd(8'h10); check(v, 32'h00201f40);
		rd(8'h14); check(v, 32'h2222222);
		rd(8'h18); check(v, 32'h0a);
		rd(8'h1c); check(v, 32'h01);
		rd(8'h30); check(v, 32'h0); // Unmapped reads as zero
		wr(LIVE, 32'h1fff); rd(LIVE); check(v, 32'h0);
		check(32'({irq_n, out_en}), 32'hff);
		check(32'({lr_n, ld_n, lc_n, la_n, xalarm, hold, casc}), 32'h78);
	endtask : t_reset
	task automatic t_los;
		wr(8'h0c, 32'h1ffe);
		run[0] <= 1'b0;
		poll(0, 1'b1, 200);
		rd(STICKY); check(v, 32'h1);
		check(32'(irq_n), 32'h0);
		wr(STICKY, 32'h1); check(32'(irq_n), 32'h1);
		rd(STICKY); check(v, 32'h0);
		run[0] <= 1'b1;
		poll(0, 1'b0, 50);
		rd(STICKY); check(v, 32'h1);
		check(32'(irq_n), 32'h0);
		wr(STICKY, 32'h1fff); check(32'(irq_n), 32'h1);
	endtask : t_los
	task automatic t_xtal;
		run[4] <= 1'b0;
		poll(4, 1'b1, 200);
		check(32'({xalarm, out_en}), 32'h80);
		wr(CTRL, 32'h007); @(negedge clock_in); check(32'(out_en), 32'h7f);
		wr(CTRL, 32'h003);
		run[4] <= 1'b1;
		poll(4, 1'b0, 50);
	endtask : t_xtal
	task automatic t_hold;
		run[5] <= 1'b0;
		for (int i = 0; i < 600 && hold !== 1'b1; i++) @(negedge clock_in);
		check(32'(hold), 32'h1);
		rd(LIVE); check(v, 32'h0);
		wr(CTRL, 32'h013); @(negedge clock_in); check(32'(hold), 32'h0);
		wr(CTRL, 32'h023); check(32'(hold), 32'h0);
		wr(CTRL, 32'h003);
		run[5] <= 1'b1;
	endtask : t_hold
	task automatic t_gap;
		wr(STICKY, 32'h1fff);
		gap[0] <= 1'b1;
		repeat (800) @(negedge clock_in);
		rd(STICKY); check(v, 32'h0);
		gap[0] <= 1'b0;
	endtask : t_gap
	task automatic t_range;
		offs[0] <= 20'd64001; poll(5, 1'b1, 10);
		offs[0] <= 20'd64000; poll(5, 1'b0, 10);
		wr(CTRL, 32'h002);
		offs[0] <= 20'd64001; repeat (5) @(negedge clock_in);
		rd(LIVE); check(32'(v[5]), 32'h0);
		offs[0] <= 20'd8001; meas(); poll(5, 1'b1, 5);
		offs[0] <= 20'd7968; meas(); repeat (3) @(negedge clock_in);
		rd(LIVE); check(32'(v[5]), 32'h1);
		offs[0] <= 20'd7967; meas(); poll(5, 1'b0, 5);
		wr(CTRL, 32'h202); // Input 1 becomes the zero reference
		offs[1] <= 20'd8001; meas(); poll(8, 1'b1, 5);
		rd(LIVE); check(32'(v[5]), 32'h0);
		offs <= '0; wr(CTRL, 32'h003); meas(); poll(8, 1'b0, 5);
	endtask : t_range
	task automatic t_lock;
		wr(STICKY, 32'h1fff); // Range changes left sticky bits behind
		for (int k = 0; k < 4; k++) begin
			pd[k] <= 18'd11; poll(9 + k, 1'b1, 5);
			check(32'({lr_n, ld_n, lc_n, la_n}), 32'(4'hf ^ (4'h1 << k)));
			pd[k] <= 18'd0; poll(9 + k, 1'b0, 5);
		end
		rd(STICKY); check(v, 32'h1e00);
		wr(8'h20, 32'h2);
		pd[0] <= 18'd11; poll(9, 1'b1, 5);
		pd[0] <= 18'd5; repeat (20) @(negedge clock_in);
		rd(LIVE); check(32'(v[9]), 32'h1);
		pd[0] <= 18'd0; repeat (80) @(negedge clock_in);
		rd(LIVE); check(32'(v[9]), 32'h1);
		poll(9, 1'b0, 150);
		wr(8'h24, 32'h1); rd(LIVE); check(32'(v[9]), 32'h1);
		check(32'({la_n, lsel}), 32'h001);
		poll(9, 1'b0, 150);
		wr(STICKY, 32'h1fff);
	endtask : t_lock
	task automatic t_out;
		wr(8'h28, 32'h2186); check(32'(xsel), 32'h2186);
		wr(CTRL, 32'h00b); check(32'(casc), 32'h1);
		wr(CTRL, 32'h003); check(32'(casc), 32'h0);
	endtask : t_out
	// Verdict and end of run, shared by the main sequence and the watchdog
	task automatic stop_test;
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// Main sequence: reset, let monitors settle, clear sticky, run scenarios
	initial begin
		{rstn_in, wr_in, rd_in, freq_valid_in, addr_in, wdata_in} = '0;
		{offs, pd, gap} = '0;
		run = 7'h7f;
		repeat (4) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (500) @(posedge clock_in);
		wr(STICKY, 32'h1fff);
		t_reset(); t_los(); t_xtal(); t_hold(); t_gap(); t_range(); t_lock(); t_out();
		stop_test();
	end
	// Watchdog at 20000 cycles, several times the expected run
	initial begin
		#200000;
		failures++;
		stop_test();
	end
endmodule : tb
